// [i2c_triple_slave_events_ctrl_tb.sv]
`timescale 1ns/10ps
module i2c_triple_slave_events_ctrl_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        wait_mode = 1'b0;
  logic        halt_mode = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe;
  logic        irq_pair, irq_third, wake_req, page_len_bad;
  logic [8:0]  page_len;
  logic        m_scl, m_sda, ack;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          samples_checked = 0;
  wire         scl = ~(m_scl | (scl_oe & ~scl_o));
  wire         sda = ~(m_sda | (sda_oe & ~sda_o));
  // =============================================================
  // Clock, design and bus master
  always #2.5 hclk = ~hclk;
  tsev_events i_tsev_events (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .wait_mode(wait_mode),
    .halt_mode(halt_mode), .irq_pair(irq_pair), .irq_third(irq_third), .wake_req(wake_req),
    .page_len(page_len), .page_len_bad(page_len_bad));
  tsev_i2c_master i_tsev_i2c_master (.scl_low(m_scl), .sda_low(m_sda), .sda(sda));
  // =============================================================
  // Bus tasks: address phase held until hready, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task automatic chk_word(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    samples_checked++;
    if (rd !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, rd, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic settle();
    repeat (12) @(posedge hclk);
  endtask : settle
  task automatic final_report();
    $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // Watchdog far beyond the few microseconds the tests need
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
  // =============================================================
  // Test sequence
  initial begin
    logic [8:0] pl [4];
    pl = '{9'h008, 9'h010, 9'h100, 9'h000};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    chk_word(8'h00, 32'h0);
    chk_word(8'h04, 32'h0);
    wr(8'h00, 32'hdf);
    chk_word(8'h00, 32'h0);
    wr(8'h08, 32'h04);
    wr(8'h0c, 32'h6100a1);                   // Slave one 0x50, slave three 0x30
    wr(8'h00, 32'hdf);
    chk_word(8'h00, 32'hdf);
    wr(8'h00, 32'h09);
    wait_mode <= 1'b1;
    // Read from slave three closed by repeated start, then write to slave one
    i_tsev_i2c_master.start();
    i_tsev_i2c_master.write_byte(8'h61, ack);
    chk_bit(ack, 1'b1);
    i_tsev_i2c_master.read_byte(1'b1);
    settle();
    chk_bit(irq_third, 1'b0);
    i_tsev_i2c_master.start();
    i_tsev_i2c_master.write_byte(8'ha0, ack);
    chk_bit(ack, 1'b1);
    chk_bit(irq_third, 1'b1);
    chk_bit(wake_req, 1'b1);
    chk_word(8'h04, 32'h04);
    chk_bit(irq_third, 1'b1);
    i_tsev_i2c_master.write_byte(8'h05, ack);
    settle();
    chk_bit(irq_pair, 1'b0);
    i_tsev_i2c_master.stop();
    settle();
    chk_bit(irq_pair, 1'b1);
    chk_word(8'h04, 32'h0c);
    chk_word(8'h04, 32'h00);
    chk_bit(irq_pair, 1'b0);
    chk_bit(irq_third, 1'b0);
    chk_word(8'h08, 32'h06);
    wr(8'h08, 32'h06);
    chk_word(8'h08, 32'h06);
    wr(8'h08, 32'h04);
    chk_word(8'h08, 32'h04);
    // Page length of each code with no slave addressed
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, c << 6);
      settle();
      chk_bit(page_len === pl[c], 1'b1);
      chk_bit(page_len_bad, c == 3);
    end
    // Misplaced stop while writing slave three
    // Full page code selected, so slave three shows its shorter area
    wr(8'h00, 32'h90);
    i_tsev_i2c_master.start();
    i_tsev_i2c_master.write_byte(8'h60, ack);
    chk_bit(page_len === 9'h080, 1'b1);
    i_tsev_i2c_master.part_byte(3);
    i_tsev_i2c_master.stop();
    settle();
    chk_bit(irq_third, 1'b1);
    chk_bit(irq_pair, 1'b0);
    chk_bit(scl_oe, 1'b0);
    // Halt: nothing stored, nothing acknowledged, no wake-up
    halt_mode <= 1'b1;
    settle();
    chk_bit(wake_req, 1'b0);
    wr(8'h00, 32'h11);
    chk_word(8'h00, 32'h90);
    i_tsev_i2c_master.start();
    i_tsev_i2c_master.write_byte(8'ha0, ack);
    chk_bit(ack, 1'b0);
    i_tsev_i2c_master.stop();
    halt_mode <= 1'b0;
    settle();
    chk_word(8'h04, 32'h40);
    settle();
    chk_bit(irq_third, 1'b0);
    // Misplaced start: next byte is an address again
    i_tsev_i2c_master.start();
    i_tsev_i2c_master.write_byte(8'ha0, ack);
    i_tsev_i2c_master.part_byte(2);
    i_tsev_i2c_master.start();
    i_tsev_i2c_master.write_byte(8'ha0, ack);
    chk_bit(ack, 1'b1);
    i_tsev_i2c_master.write_byte(8'h33, ack);
    i_tsev_i2c_master.stop();
    settle();
    chk_bit(irq_pair, 1'b1);
    chk_word(8'h04, 32'h48);
    wr(8'h08, 32'h04);
    // Error flag with the error enable off
    wr(8'h00, 32'h00);
    i_tsev_i2c_master.start();
    i_tsev_i2c_master.write_byte(8'ha0, ack);
    i_tsev_i2c_master.part_byte(4);
    i_tsev_i2c_master.stop();
    settle();
    chk_bit(irq_pair, 1'b0);
    chk_word(8'h04, 32'h40);
    // Unacked_no_stop_flag on a read of slave three, then the clock runs on
    wr(8'h00, 32'h10);
    i_tsev_i2c_master.start();
    i_tsev_i2c_master.write_byte(8'h61, ack);
    i_tsev_i2c_master.read_byte(1'b1);
    i_tsev_i2c_master.part_byte(1);
    settle();
    chk_bit(irq_third, 1'b1);
    i_tsev_i2c_master.stop();
    settle();
    chk_word(8'h04, 32'hc0);
    wr(8'h00, 32'hdf);
    wr(8'h08, 32'h00);
    chk_word(8'h00, 32'h00);
    chk_bit(scl_o | sda_o | hresp, 1'b0);
    final_report();
  end
endmodule : i2c_triple_slave_events_ctrl_tb

// [tsev_events.sv]
`timescale 1ns/10ps
// Overview of operation
// - Misplaced start/stop sets bus error, gated interrupt
// - Error on stop: drop byte, release, idle
// - Error on start: drop byte, expect address
// - Unacked_no_stop_flag without stop sets error flag
// - Write done after end; read clears when idle
// - Read done after end; read clears when idle
// - Write hold cleared only by software zero
// - Repeated start ends transfer like stop
// - Wait: normal operation, interrupts wake
// - Halt: freeze registers, acknowledge nothing
// - No event wakes from halt
// - Read/write interrupts only after transfer end
// - Error interrupt goes to addressed slave line
// - Page length code selects 8/16/full/invalid
// - Control one cleared while peripheral off
// - Bit four gates both error interrupts
// - Read enables: third and shared pair
// - Write enables: third and shared pair
// - Control one resets to zero
// - Pair shares a line, third separate
// - Clock never held low; read clears error
module tsev_events (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        wait_mode,
  input  wire logic        halt_mode,
  output logic             irq_pair,
  output logic             irq_third,
  output logic             wake_req,
  output logic      [8:0]  page_len,
  output logic             page_len_bad
);

  // =============================================================
  // Decoding helpers
  function automatic logic [2:0] addr_match(input logic [6:0] a, input logic [23:0] cfg);
    logic [2:0] m;
    m = 3'b000;
    for (int i = 0; i < 3; i++) begin
      m[i] = cfg[8*i] && (cfg[8*i+1 +: 7] == a);
    end
    return m;
  endfunction : addr_match

  function automatic logic [8:0] page_bytes(input logic [1:0] sel, input logic third);
    case (sel)
      2'b00:   page_bytes = tsev_pkg::TSEV_PAGE_SHORT;
      2'b01:   page_bytes = tsev_pkg::TSEV_PAGE_MID;
      2'b10:   page_bytes = third ? tsev_pkg::TSEV_PAGE_FULL3 : tsev_pkg::TSEV_PAGE_FULL12;
      default: page_bytes = 9'h000;
    endcase
  endfunction : page_bytes

  // =============================================================
  // Declarations
  logic [7:0]  ctrl1_r;
  logic        periph_on_r;
  logic        write_hold_r;
  logic [23:0] addr_cfg_r;
  logic        bus_error_flag_r;
  logic        unacked_no_stop_flag_r;
  logic [2:0]  write_done_flag_r;
  logic [2:0]  read_done_flag_r;
  logic        err_third_r;
  logic        scl_meta_r, scl_sync_r, scl_prev_r;
  logic        sda_meta_r, sda_sync_r, sda_prev_r;
  tsev_pkg::tsev_state_t state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [2:0]  hit_r;
  logic        dir_r;
  logic        ack_due_r;
  logic        pend_unacked_no_stop_flag_r;
  logic        busy_r;
  logic        wr_pend_r;
  logic [7:0]  wr_ofs_r;
  logic [31:0] rdata_nxt;
  logic        irq_pair_nxt, irq_third_nxt;

  wire logic active     = periph_on_r && !halt_mode;
  wire logic scl_rise   = scl_sync_r && !scl_prev_r;
  wire logic scl_fall   = !scl_sync_r && scl_prev_r;
  wire logic start_evt  = scl_sync_r && scl_prev_r && sda_prev_r && !sda_sync_r;
  wire logic stop_evt   = scl_sync_r && scl_prev_r && !sda_prev_r && sda_sync_r;
  // First clock high after a byte may carry a legal stop or restart
  wire logic mid_byte   = (state_r != tsev_pkg::TSEV_IDLE) && (bit_cnt_r > 4'h1);
  wire logic bus_error_flag_evt   = active && (start_evt || stop_evt) && mid_byte;
  // Unacked_no_stop_flag is an error only once the clock falls again with no end condition
  wire logic unacked_no_stop_flag_evt   = active && pend_unacked_no_stop_flag_r && scl_fall && (bit_cnt_r == 4'h1)
                          && !start_evt && !stop_evt;
  wire logic end_evt    = active && (start_evt || stop_evt) && !mid_byte
                          && (state_r == tsev_pkg::TSEV_DATA);
  wire logic [2:0] wd_set = (end_evt && !dir_r) ? hit_r : 3'b000;
  wire logic [2:0] rd_set = (end_evt && dir_r) ? hit_r : 3'b000;
  wire logic [2:0] new_hit = addr_match(shift_r[6:0], addr_cfg_r);
  wire logic addr_ok    = (|new_hit) && !write_hold_r;

  // Bus address phase decode
  wire logic bus_take   = hsel && hready && htrans[1];
  wire logic bus_rd     = bus_take && !hwrite;
  wire logic st_rd      = bus_rd && !halt_mode && (haddr[7:0] == tsev_pkg::TSEV_OFS_STATUS);
  wire logic wr_now     = wr_pend_r && !halt_mode;
  wire logic err_any    = bus_error_flag_r || unacked_no_stop_flag_r;

  // =============================================================
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_i;
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_meta_r <= sda_i;
      sda_sync_r <= sda_meta_r;
      sda_prev_r <= sda_sync_r;
    end
  end

  // =============================================================
  // Byte engine: framing, address capture, direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= tsev_pkg::TSEV_IDLE;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      hit_r       <= 3'b000;
      dir_r       <= 1'b0;
      ack_due_r   <= 1'b0;
      pend_unacked_no_stop_flag_r <= 1'b0;
      busy_r      <= 1'b0;
    end else if (!active) begin
      state_r     <= tsev_pkg::TSEV_IDLE;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      hit_r       <= 3'b000;
      ack_due_r   <= 1'b0;
      pend_unacked_no_stop_flag_r <= 1'b0;
      busy_r      <= 1'b0;
    end else if (start_evt) begin
      state_r     <= tsev_pkg::TSEV_ADDR;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      hit_r       <= 3'b000;
      ack_due_r   <= 1'b0;
      pend_unacked_no_stop_flag_r <= 1'b0;
      busy_r      <= 1'b1;
    end else if (stop_evt) begin
      state_r     <= tsev_pkg::TSEV_IDLE;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      hit_r       <= 3'b000;
      ack_due_r   <= 1'b0;
      pend_unacked_no_stop_flag_r <= 1'b0;
      busy_r      <= 1'b0;
    end else if (scl_rise && state_r != tsev_pkg::TSEV_IDLE) begin
      if (bit_cnt_r == tsev_pkg::TSEV_ACK_BIT) begin
        // Ack slot: master answer on reads decides unacked_no_stop_flag tracking
        bit_cnt_r <= 4'h0;
        ack_due_r <= 1'b0;
        pend_unacked_no_stop_flag_r <= (state_r == tsev_pkg::TSEV_DATA) && dir_r && sda_sync_r;
      end else begin
        shift_r     <= {shift_r[6:0], sda_sync_r};
        bit_cnt_r   <= bit_cnt_r + 4'h1;
        // Pending unacked_no_stop_flag survives the first clock high, where stop or restart clears it
        pend_unacked_no_stop_flag_r <= pend_unacked_no_stop_flag_r && (bit_cnt_r == 4'h0);
        if (bit_cnt_r == tsev_pkg::TSEV_LAST_BIT) begin
          case (state_r)
            tsev_pkg::TSEV_ADDR: begin
              state_r   <= addr_ok ? tsev_pkg::TSEV_DATA : tsev_pkg::TSEV_IGNORE;
              hit_r     <= addr_ok ? new_hit : 3'b000;
              dir_r     <= sda_sync_r;
              ack_due_r <= addr_ok;
            end
            tsev_pkg::TSEV_DATA: begin
              ack_due_r <= !dir_r;
            end
            default: begin
              ack_due_r <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // =============================================================
  // Pin drivers; clock line is never stretched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_oe <= 1'b0;
    end else if (!active || start_evt || stop_evt) begin
      sda_oe <= 1'b0;
    end else if (scl_fall && bit_cnt_r == tsev_pkg::TSEV_ACK_BIT && ack_due_r) begin
      sda_oe <= 1'b1;
    end else if (scl_fall && bit_cnt_r == 4'h0) begin
      sda_oe <= 1'b0;
    end
  end

  // Constant drive levels kept in flops so outputs stay registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_o  <= 1'b0;
      scl_o  <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      sda_o  <= 1'b0;
      scl_o  <= 1'b0;
      scl_oe <= 1'b0;
    end
  end

  // =============================================================
  // Error flags; a new event wins over the read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_error_flag_r       <= 1'b0;
      unacked_no_stop_flag_r <= 1'b0;
      err_third_r            <= 1'b0;
    end else if (!periph_on_r) begin
      bus_error_flag_r       <= 1'b0;
      unacked_no_stop_flag_r <= 1'b0;
      err_third_r            <= 1'b0;
    end else if (!halt_mode) begin
      bus_error_flag_r       <= bus_error_flag_evt || (bus_error_flag_r && !st_rd);
      unacked_no_stop_flag_r <= unacked_no_stop_flag_evt || (unacked_no_stop_flag_r && !st_rd);
      if (bus_error_flag_evt || unacked_no_stop_flag_evt) begin
        err_third_r <= hit_r[2];
      end
    end
  end

  // Completion flags; cleared by a read only while no transfer runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_done_flag_r <= 3'b000;
      read_done_flag_r  <= 3'b000;
    end else if (!periph_on_r) begin
      write_done_flag_r <= 3'b000;
      read_done_flag_r  <= 3'b000;
    end else if (!halt_mode) begin
      write_done_flag_r <= wd_set | (write_done_flag_r & {3{!(st_rd && !busy_r)}});
      read_done_flag_r  <= rd_set | (read_done_flag_r & {3{!(st_rd && !busy_r)}});
    end
  end

  // =============================================================
  // Interrupt lines, level while flag and enable both stand
  always_comb begin
    irq_pair_nxt  = ((|write_done_flag_r[1:0]) && ctrl1_r[tsev_pkg::TSEV_C1_WR12_EN])
                 || ((|read_done_flag_r[1:0]) && ctrl1_r[tsev_pkg::TSEV_C1_RD12_EN])
                 || (err_any && ctrl1_r[tsev_pkg::TSEV_C1_ERR_EN] && !err_third_r);
    irq_third_nxt = (write_done_flag_r[2] && ctrl1_r[tsev_pkg::TSEV_C1_WR3_EN])
                 || (read_done_flag_r[2] && ctrl1_r[tsev_pkg::TSEV_C1_RD3_EN])
                 || (err_any && ctrl1_r[tsev_pkg::TSEV_C1_ERR_EN] && err_third_r);
  end

  // Frozen in halt; wake only offered from wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pair  <= 1'b0;
      irq_third <= 1'b0;
      wake_req  <= 1'b0;
    end else if (!halt_mode) begin
      irq_pair  <= irq_pair_nxt;
      irq_third <= irq_third_nxt;
      wake_req  <= wait_mode && (irq_pair_nxt || irq_third_nxt);
    end else begin
      wake_req  <= 1'b0;
    end
  end

  // =============================================================
  // Page length of the slave being addressed; slave one/two lengths when none is
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_len     <= tsev_pkg::TSEV_PAGE_SHORT;
      page_len_bad <= 1'b0;
    end else if (!halt_mode) begin
      page_len     <= page_bytes(ctrl1_r[tsev_pkg::TSEV_C1_PAGE_HI:tsev_pkg::TSEV_C1_PAGE_LO],
                                 hit_r[2]);
      page_len_bad <= &ctrl1_r[tsev_pkg::TSEV_C1_PAGE_HI:tsev_pkg::TSEV_C1_PAGE_LO];
    end
  end

  // =============================================================
  // AHB-Lite slave: zero wait, OKAY always, read data set up early
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (haddr[7:0])
      tsev_pkg::TSEV_OFS_CTRL1:  rdata_nxt = {24'h000000, ctrl1_r};
      tsev_pkg::TSEV_OFS_STATUS: rdata_nxt = {24'h000000, unacked_no_stop_flag_r,
                                              bus_error_flag_r, write_done_flag_r,
                                              read_done_flag_r};
      tsev_pkg::TSEV_OFS_CTRL2:  rdata_nxt = {29'h00000000, periph_on_r, write_hold_r, 1'b0};
      tsev_pkg::TSEV_OFS_ADDR:   rdata_nxt = {8'h00, addr_cfg_r};
      default:                   rdata_nxt = 32'h00000000;
    endcase
  end

  // Address phase capture and read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend_r <= bus_take && hwrite && (hsize == 3'b010);
        wr_ofs_r  <= haddr[7:0];
      end
      if (bus_rd) begin
        hrdata <= rdata_nxt;
      end
    end
  end

  // Control one; peripheral off forces it to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_r <= tsev_pkg::TSEV_C1_RESET;
    end else if (!periph_on_r) begin
      ctrl1_r <= tsev_pkg::TSEV_C1_RESET;
    end else if (wr_now && wr_ofs_r == tsev_pkg::TSEV_OFS_CTRL1) begin
      ctrl1_r <= hwdata[7:0] & tsev_pkg::TSEV_C1_WMASK;
    end
  end

  // Control two; hold flag set by hardware, cleared by a written zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_on_r  <= 1'b0;
      write_hold_r <= 1'b0;
    end else if (!halt_mode) begin
      if (wr_now && wr_ofs_r == tsev_pkg::TSEV_OFS_CTRL2) begin
        periph_on_r <= hwdata[tsev_pkg::TSEV_C2_ON];
      end
      if (|wd_set) begin
        write_hold_r <= 1'b1;
      end else if (wr_now && wr_ofs_r == tsev_pkg::TSEV_OFS_CTRL2
                   && !hwdata[tsev_pkg::TSEV_C2_HOLD]) begin
        write_hold_r <= 1'b0;
      end
    end
  end

  // Slave addresses; cleared while the peripheral is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_cfg_r <= tsev_pkg::TSEV_ADDR_RESET;
    end else if (!periph_on_r) begin
      addr_cfg_r <= tsev_pkg::TSEV_ADDR_RESET;
    end else if (wr_now && wr_ofs_r == tsev_pkg::TSEV_OFS_ADDR) begin
      addr_cfg_r <= hwdata[23:0];
    end
  end

  // =============================================================
  // Checks
  sequence s_status_clear;
    st_rd && !bus_error_flag_evt && periph_on_r;
  endsequence

  sequence s_third_pending;
    (((write_done_flag_r[2] && ctrl1_r[tsev_pkg::TSEV_C1_WR3_EN])
      || (read_done_flag_r[2] && ctrl1_r[tsev_pkg::TSEV_C1_RD3_EN])) && !halt_mode) [*2];
  endsequence

  ctrl_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !periph_on_r |=> (ctrl1_r == 8'h00))
    else $error("control one not cleared while off");
  bus_error_flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_error_flag_evt |=> bus_error_flag_r ##0 (state_r != tsev_pkg::TSEV_DATA))
    else $error("bus error not flagged or engine kept data");
  err_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_status_clear |=> !bus_error_flag_r)
    else $error("status read left bus error set");
  third_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_third_pending |-> irq_third)
    else $error("third line not raised for pending write");
  err_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ctrl1_r[4] && !ctrl1_r[2] && !ctrl1_r[0] && !halt_mode) |=> !irq_pair)
    else $error("pair line raised with all enables low");
  hold_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (write_hold_r && !(wr_now && wr_ofs_r == 8'h08)) |=> write_hold_r)
    else $error("hold flag dropped without software");
  halt_freeze_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (halt_mode && $past(halt_mode)) |-> $stable(read_done_flag_r) && !sda_oe)
    else $error("state moved or ack driven in halt");
  done_late_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(|read_done_flag_r) || $rose(|write_done_flag_r)) |-> $past(start_evt || stop_evt))
    else $error("completion flag without transfer end");
  halt_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
    halt_mode |=> !wake_req)
    else $error("wake offered from halt");
  scl_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_error_flag_r |-> !scl_oe)
    else $error("clock line held during bus error");

endmodule : tsev_events

// [tsev_i2c_master.sv]
`timescale 1ns/10ps
// =============================================================
// Behavioural bus master, open drain: a high drive pulls low
module tsev_i2c_master (
  output logic scl_low,
  output logic sda_low,
  input  wire logic sda
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // One bit, SCL period 64 ns; SCL parked high between frames
  task automatic put_bit(input logic b);
    sda_low = ~b;
    #16 scl_low = 1'b0;
    #32 scl_low = 1'b1;
    #16;
  endtask : put_bit
  // Also serves as repeated start
  task automatic start();
    sda_low = 1'b0;
    #16 scl_low = 1'b0;
    #32 sda_low = 1'b1;
    #32 scl_low = 1'b1;
    #16;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #16 scl_low = 1'b0;
    #32 sda_low = 1'b0;
    #48;
  endtask : stop
  task automatic write_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    sda_low = 1'b0;
    #16 scl_low = 1'b0;
    #16 ack = (sda === 1'b0);
    #16 scl_low = 1'b1;
    #16;
  endtask : write_byte
  task automatic read_byte(input logic unacked_no_stop_flag);
    for (int i = 0; i < 8; i++) put_bit(1'b1);
    put_bit(unacked_no_stop_flag);
  endtask : read_byte
  // Broken byte: only n released bits, SCL left low
  task automatic part_byte(input int n);
    for (int i = 0; i < n; i++) put_bit(1'b1);
  endtask : part_byte
endmodule : tsev_i2c_master

// [tsev_pkg.sv]
// =============================================================
// Shared constants of the three-address slave event block
package tsev_pkg;

  // =============================================================
  // Register byte offsets on the AHB-Lite port
  localparam logic [7:0] TSEV_OFS_CTRL1  = 8'h00;
  localparam logic [7:0] TSEV_OFS_STATUS = 8'h04;
  localparam logic [7:0] TSEV_OFS_CTRL2  = 8'h08;
  localparam logic [7:0] TSEV_OFS_ADDR   = 8'h0c;

  // =============================================================
  // Control one fields
  localparam int         TSEV_C1_PAGE_HI  = 7;
  localparam int         TSEV_C1_PAGE_LO  = 6;
  localparam int         TSEV_C1_ERR_EN   = 4;
  localparam int         TSEV_C1_RD3_EN   = 3;
  localparam int         TSEV_C1_RD12_EN  = 2;
  localparam int         TSEV_C1_WR3_EN   = 1;
  localparam int         TSEV_C1_WR12_EN  = 0;
  localparam logic [7:0] TSEV_C1_WMASK    = 8'hdf;
  localparam logic [7:0] TSEV_C1_RESET    = 8'h00;

  // =============================================================
  // Control two and status fields
  localparam int         TSEV_C2_ON       = 2;
  localparam int         TSEV_C2_HOLD     = 1;
  localparam int         TSEV_ST_UNACKED_NO_STOP_FLAG     = 7;
  localparam int         TSEV_ST_BUS_ERROR_FLAG     = 6;
  localparam int         TSEV_ST_WD_LO    = 3;
  localparam int         TSEV_ST_RD_LO    = 0;
  localparam logic [7:0] TSEV_ST_RESET    = 8'h00;
  localparam logic [23:0] TSEV_ADDR_RESET = 24'h000000;

  // =============================================================
  // Page lengths and byte engine constants
  localparam logic [8:0] TSEV_PAGE_SHORT  = 9'h008;
  localparam logic [8:0] TSEV_PAGE_MID    = 9'h010;
  localparam logic [8:0] TSEV_PAGE_FULL12 = 9'h100;
  localparam logic [8:0] TSEV_PAGE_FULL3  = 9'h080;
  localparam logic [3:0] TSEV_ACK_BIT     = 4'h8;
  localparam logic [3:0] TSEV_LAST_BIT    = 4'h7;

  // Byte engine states, Gray along idle-address-data
  typedef enum logic [1:0] {
    TSEV_IDLE   = 2'b00,
    TSEV_ADDR   = 2'b01,
    TSEV_DATA   = 2'b11,
    TSEV_IGNORE = 2'b10
  } tsev_state_t;

endpackage : tsev_pkg
